// ---- dadc_bus_model.sv ----
// memory and io model on the far side of the engine's system bus
// assumes byte at address a holds a[7:0]^0x5a; writes are only observed
`timescale 1ns/1ps
module dadc_bus_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // behaviour chosen by the bench
  input wire logic slow,
  input wire logic err_en,
  input wire logic [31:0] err_addr,
  // system bus slave side
  input wire logic sys_req,
  input wire logic [31:0] sys_addr,
  output logic sys_ack,
  output logic sys_err,
  output logic [31:0] sys_rdata
);
  logic [1:0] wait_r;
  logic go;
  logic [7:0] b;
  assign b = sys_addr[7:0];
  // slow mode answers after three idle cycles, otherwise at once
  assign go = sys_req && !sys_ack && !sys_err && (!slow || wait_r == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  // idle read data toggles so a late sample never matches by chance
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wait_r <= 2'h0;
      sys_ack <= 1'b0;
      sys_err <= 1'b0;
      sys_rdata <= 32'h0;
    end
    else
    begin
      wait_r <= (!sys_req || sys_ack || sys_err) ? 2'h0 : wait_r + 2'h1;
      sys_ack <= go && !(err_en && sys_addr == err_addr);
      sys_err <= go && err_en && sys_addr == err_addr;
      sys_rdata <= go ? {b + 8'h3, b + 8'h2, b + 8'h1, b} ^ 32'h5a5a5a5a
        : ~sys_rdata;
    end
  end
endmodule // dadc_bus_model

// ---- dadc_engine.sv ----
// eight-channel dual-address dma engine with register port
// assumes one mclk domain; system bus answers with ack or err pulses
`timescale 1ns/1ps
`include "dadc_params.svh"

module dadc_engine #(
  parameter int NCH = 8,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // system bus master
  output logic sys_req,
  output logic sys_we,
  output logic [31:0] sys_addr,
  output dadc_pkg::dadc_size_t sys_size,
  output logic [31:0] sys_wdata,
  input wire logic sys_ack,
  input wire logic sys_err,
  input wire logic [31:0] sys_rdata,
  // transfer requests; intc active low, pin polarity set by each channel's POS bit
  input wire logic [NCH-1:0] intc_transfer_req_n,
  input wire logic [NCH-1:0] pin_transfer_req_n,
  // completion interrupt
  output logic transfer_done_irq
);
  import dadc_pkg::*;

  localparam int CW = $clog2(NCH);

  typedef struct packed {
    dadc_state_e state;
    logic [CW-1:0] cur;
    logic [2:0] offs;
    logic [31:0] hold;
    logic [NCH-1:0][31:0] src;
    logic [NCH-1:0][31:0] dst;
    logic [NCH-1:0][31:0] cnt;
    logic [NCH-1:0][`DADC_CTL_W-1:0] ctl;
    logic [NCH-1:0][`DADC_ST_W-1:0] st;
    logic bus_req;
    logic bus_we;
    logic [31:0] bus_addr;
    logic [31:0] bus_wdata;
    dadc_size_t bus_size;
    logic [31:0] rd_data;
    logic irq;
  } dadc_core_s;

  dadc_core_s core_r;
  dadc_core_s core_nxt;
  logic [NCH-1:0] take;
  logic [NCH-1:0] pin_req;
  logic [NCH-1:0] lev_sel;
  logic [NCH-1:0] pos_sel;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // bytes in one unit, port or memory bus for a width code
  function automatic logic [2:0] width_bytes(input dadc_size_t code);
    if (!code[1])
      width_bytes = 3'h4;
    else if (code[0])
      width_bytes = 3'h1;
    else
      width_bytes = 3'h2;
  endfunction

  // width code for a byte count of 1, 2 or 4
  function automatic dadc_size_t size_code(input logic [2:0] bytes);
    if (bytes == 3'h4)
      size_code = `DADC_SZ_32;
    else if (bytes == 3'h2)
      size_code = `DADC_SZ_16;
    else
      size_code = `DADC_SZ_8;
  endfunction

  // one access is the unit cut down to the width of the side being accessed
  function automatic logic [2:0] access_bytes(
    input logic [`DADC_CTL_W-1:0] c,
    input logic dest_side
  );
    logic [2:0] ub;
    logic [2:0] wb;
    ub = width_bytes(c[`DADC_CTL_UNIT +: 2]);
    if (dest_side ? c[`DADC_CTL_DIO] : c[`DADC_CTL_SIO])
      wb = width_bytes(c[`DADC_CTL_PORT +: 2]);
    else if (dest_side)
      wb = width_bytes(c[`DADC_CTL_DMEM +: 2]);
    else
      wb = width_bytes(c[`DADC_CTL_SMEM +: 2]);
    access_bytes = (wb < ub) ? wb : ub;
  endfunction

  // low-lane mask for a 1, 2 or 4 byte access
  function automatic logic [31:0] lane_mask(input logic [2:0] bytes);
    if (bytes == 3'h4)
      lane_mask = 32'hffffffff;
    else if (bytes == 3'h2)
      lane_mask = 32'h0000ffff;
    else
      lane_mask = 32'h000000ff;
  endfunction

  // nonzero when a value is not a whole multiple of the unit
  function automatic logic misaligned(
    input logic [31:0] v,
    input logic [2:0] ub
  );
    misaligned = |(v[1:0] & (ub[1:0] - 2'h1)) |
                 (ub == 3'h4 && v[1:0] != 2'h0);
  endfunction

  // start-time configuration check on the value being written
  function automatic logic config_bad(
    input logic [`DADC_CTL_W-1:0] c,
    input logic [`DADC_ST_W-1:0] s,
    input logic [31:0] sa,
    input logic [31:0] da,
    input logic [31:0] bc
  );
    logic [2:0] ub;
    logic [2:0] pb;
    ub = width_bytes(c[`DADC_CTL_UNIT +: 2]);
    pb = width_bytes(c[`DADC_CTL_PORT +: 2]);
    config_bad = (c[`DADC_CTL_SIO] & c[`DADC_CTL_DIO]) |
                 s[`DADC_ST_NC] | s[`DADC_ST_ABC] |
                 (pb > ub) |
                 misaligned(bc, ub) | misaligned(sa, ub) |
                 misaligned(da, ub) | (bc == 32'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin request conditioning, per channel mode bits
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      lev_sel[i] = core_r.ctl[i][`DADC_CTL_LEV];
      pos_sel[i] = core_r.ctl[i][`DADC_CTL_POS];
    end
  end

  dadc_req_cond #(
    .N(NCH)
  ) u_req_cond (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_n(pin_transfer_req_n),
    .level_sel(lev_sel),
    .polarity_sel(pos_sel),
    .take(take),
    .pin_req(pin_req)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state: register port first, engine after so its sets win
  always_comb
  begin
    logic [CW-1:0] ch;
    logic [2:0] rsel;
    logic mapped;
    logic [NCH-1:0] want;
    logic found;
    logic [CW-1:0] pick;
    logic [`DADC_CTL_W-1:0] cc;
    logic [2:0] ub;
    logic [2:0] ab;
    logic [2:0] nofs;
    logic [31:0] merged;
    logic [31:0] left;
    ch = reg_addr[`DADC_CH_LSB +: CW];
    rsel = reg_addr[`DADC_REG_LSB +: 3];
    mapped = (reg_addr[1:0] == 2'h0) && (int'(ch) < NCH) &&
             (reg_addr[AW-1:`DADC_CH_LSB] < NCH);
    want = '0;
    found = 1'b0;
    pick = '0;
    cc = core_r.ctl[core_r.cur];
    ub = width_bytes(cc[`DADC_CTL_UNIT +: 2]);
    ab = 3'h0;
    nofs = 3'h0;
    merged = 32'h0;
    left = 32'h0;
    take = '0;
    core_nxt = core_r;
    core_nxt.rd_data = 32'h0; // read data stands one cycle only

    // register writes
    if (reg_wr && mapped)
    begin
      if (rsel == `DADC_REG_SRC)
        core_nxt.src[ch] = reg_wdata;
      else if (rsel == `DADC_REG_DST)
        core_nxt.dst[ch] = reg_wdata;
      else if (rsel == `DADC_REG_CNT)
        core_nxt.cnt[ch] = reg_wdata;
      else if (rsel == `DADC_REG_CTL)
      begin
        // start is an action bit; it is never stored
        core_nxt.ctl[ch] = reg_wdata[`DADC_CTL_W-1:0];
        core_nxt.ctl[ch][`DADC_CTL_START] = 1'b0;
        if (reg_wdata[`DADC_CTL_START] &&
            !core_r.st[ch][`DADC_ST_ACT])
        begin
          if (config_bad(reg_wdata[`DADC_CTL_W-1:0], core_r.st[ch],
                         core_r.src[ch], core_r.dst[ch], core_r.cnt[ch]))
          begin
            // pointers untouched, nothing moves
            core_nxt.st[ch][`DADC_ST_ABC] = 1'b1;
            core_nxt.st[ch][`DADC_ST_CONF] = 1'b1;
          end
          else
            core_nxt.st[ch][`DADC_ST_ACT] = 1'b1;
        end
      end
      else if (rsel == `DADC_REG_STATE)
        // write 1 clears done and fault flags; active is read only
        core_nxt.st[ch][`DADC_ST_W-1:1] =
          core_r.st[ch][`DADC_ST_W-1:1] & ~reg_wdata[`DADC_ST_W-1:1];
    end

    // register reads
    if (reg_rd && mapped)
    begin
      if (rsel == `DADC_REG_SRC)
        core_nxt.rd_data = core_r.src[ch];
      else if (rsel == `DADC_REG_DST)
        core_nxt.rd_data = core_r.dst[ch];
      else if (rsel == `DADC_REG_CNT)
        core_nxt.rd_data = core_r.cnt[ch];
      else if (rsel == `DADC_REG_CTL)
        core_nxt.rd_data = {{(32-`DADC_CTL_W){1'b0}}, core_r.ctl[ch]};
      else if (rsel == `DADC_REG_STATE)
        core_nxt.rd_data = {{(32-`DADC_ST_W){1'b0}}, core_r.st[ch]};
    end

    // request per active channel
    for (int i = 0; i < NCH; i++)
    begin
      if (!core_r.ctl[i][`DADC_CTL_EXR])
        want[i] = core_r.st[i][`DADC_ST_ACT];
      else
        want[i] = core_r.st[i][`DADC_ST_ACT] &
                  (~intc_transfer_req_n[i] | pin_req[i]);
    end
    // highest index first so the lowest requesting channel is kept
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (want[i])
      begin
        found = 1'b1;
        pick = CW'(i);
      end
    end

    // transfer engine
    case (core_r.state)
      DADC_IDLE:
      begin
        // arbitration only happens here, between whole units
        if (found)
        begin
          cc = core_r.ctl[pick];
          ab = access_bytes(cc, 1'b0);
          take[pick] = 1'b1;
          core_nxt.cur = pick;
          core_nxt.offs = 3'h0;
          core_nxt.hold = 32'h0;
          core_nxt.bus_req = 1'b1;
          core_nxt.bus_we = 1'b0;
          core_nxt.bus_addr = core_r.src[pick];
          core_nxt.bus_size = size_code(ab);
          core_nxt.state = DADC_READ;
        end
      end
      DADC_READ:
      begin
        ab = access_bytes(cc, 1'b0);
        nofs = core_r.offs + ab;
        merged = core_r.hold |
                 ((sys_rdata & lane_mask(ab)) << {core_r.offs, 3'h0});
        if (sys_err)
        begin
          core_nxt.bus_req = 1'b0;
          core_nxt.st[core_r.cur][`DADC_ST_ABC] = 1'b1;
          core_nxt.st[core_r.cur][`DADC_ST_BES] = 1'b1;
          core_nxt.st[core_r.cur][`DADC_ST_ACT] = 1'b0;
          core_nxt.state = DADC_IDLE;
        end
        else if (sys_ack)
        begin
          core_nxt.hold = merged;
          if (nofs == ub)
          begin
            // whole unit held; now write it out
            ab = access_bytes(cc, 1'b1);
            core_nxt.offs = 3'h0;
            core_nxt.bus_we = 1'b1;
            core_nxt.bus_addr = core_r.dst[core_r.cur];
            core_nxt.bus_size = size_code(ab);
            core_nxt.bus_wdata = merged & lane_mask(ab);
            core_nxt.state = DADC_WRITE;
          end
          else
          begin
            core_nxt.offs = nofs;
            core_nxt.bus_addr = core_r.src[core_r.cur] + 32'(nofs);
          end
        end
      end
      DADC_WRITE:
      begin
        ab = access_bytes(cc, 1'b1);
        nofs = core_r.offs + ab;
        left = core_r.hold >> {nofs, 3'h0};
        if (sys_err)
        begin
          core_nxt.bus_req = 1'b0;
          core_nxt.st[core_r.cur][`DADC_ST_ABC] = 1'b1;
          core_nxt.st[core_r.cur][`DADC_ST_BED] = 1'b1;
          core_nxt.st[core_r.cur][`DADC_ST_ACT] = 1'b0;
          core_nxt.state = DADC_IDLE;
        end
        else if (sys_ack)
        begin
          if (nofs == ub)
          begin
            // unit done: step pointers, count, maybe finish
            core_nxt.bus_req = 1'b0;
            core_nxt.bus_we = 1'b0;
            core_nxt.src[core_r.cur] =
              core_r.src[core_r.cur] + 32'(ub);
            core_nxt.dst[core_r.cur] =
              core_r.dst[core_r.cur] + 32'(ub);
            core_nxt.cnt[core_r.cur] =
              core_r.cnt[core_r.cur] - 32'(ub);
            if (core_r.cnt[core_r.cur] == 32'(ub))
            begin
              core_nxt.st[core_r.cur][`DADC_ST_NC] = 1'b1;
              core_nxt.st[core_r.cur][`DADC_ST_ACT] = 1'b0;
            end
            core_nxt.state = DADC_IDLE;
          end
          else
          begin
            core_nxt.offs = nofs;
            core_nxt.bus_addr = core_r.dst[core_r.cur] + 32'(nofs);
            core_nxt.bus_wdata = left & lane_mask(ab);
          end
        end
      end
      default:
        core_nxt.state = DADC_IDLE;
    endcase

    // completion interrupt from the flags as they will stand
    core_nxt.irq = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      core_nxt.irq = core_nxt.irq |
        (core_nxt.st[i][`DADC_ST_NC] &
         core_nxt.ctl[i][`DADC_CTL_NIE]) |
        (core_nxt.st[i][`DADC_ST_ABC] &
         core_nxt.ctl[i][`DADC_CTL_ABIE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      core_r <= '0;
      core_r.state <= DADC_IDLE;
      for (int i = 0; i < NCH; i++)
      begin
        core_r.ctl[i] <= `DADC_CTL_RST;
        core_r.st[i] <= `DADC_ST_RST;
      end
    end
    else
      core_r <= core_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign reg_rdata = core_r.rd_data;
  assign sys_req = core_r.bus_req;
  assign sys_we = core_r.bus_we;
  assign sys_addr = core_r.bus_addr;
  assign sys_size = core_r.bus_size;
  assign sys_wdata = core_r.bus_wdata;
  assign transfer_done_irq = core_r.irq;

endmodule // dadc_engine

// ---- dadc_engine_monitor.sv ----
// checker for the system bus and register port of the dma engine
// assumes it is bound onto dadc_engine and sees only its ports
`timescale 1ns/1ps
module dadc_engine_monitor import dadc_pkg::*; #(
  parameter int NCH = 8,
  parameter int AW = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // system bus
  input wire logic sys_req,
  input wire logic sys_we,
  input wire logic [31:0] sys_addr,
  input wire dadc_pkg::dadc_size_t sys_size,
  input wire logic [31:0] sys_wdata,
  input wire logic sys_ack,
  input wire logic sys_err
);
  import dadc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // bytes moved by the access on the bus now
  logic [31:0] step;
  assign step = (sys_size == 2'h3) ? 32'h1 : (sys_size == 2'h2) ? 32'h2 : 32'h4;
  // an access waiting for its answer, and one being answered
  sequence s_wait;
    sys_req && !sys_ack && !sys_err;
  endsequence
  sequence s_rd_done;
    sys_req && sys_ack && !sys_we;
  endsequence
  sequence s_wr_done;
    sys_req && sys_ack && sys_we;
  endsequence
  property p_rdata_quiet;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  property p_hold;
    s_wait |=> sys_req && $stable(sys_addr) && $stable(sys_we)
      && $stable(sys_size) && $stable(sys_wdata);
  endproperty
  property p_read_first;
    $rose(sys_req) |-> !sys_we;
  endproperty
  property p_align;
    sys_req |-> (sys_size == 2'h3 || !sys_addr[0])
      && (sys_size != 2'h0 || !sys_addr[1]);
  endproperty
  property p_code;
    sys_req |-> sys_size != 2'h1;
  endproperty
  property p_err_stop;
    sys_req && sys_err |=> !sys_req;
  endproperty
  property p_wr_step;
    s_wr_done |=> !sys_req || (sys_we && sys_addr == $past(sys_addr) + $past(step));
  endproperty
  property p_rd_step;
    s_rd_done |=> !sys_req || sys_we || sys_addr == $past(sys_addr) + $past(step);
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside its read cycle");
  a_hold: assert property (p_hold)
    else $error("bus access changed before its answer");
  a_read_first: assert property (p_read_first)
    else $error("unit did not start with a source read");
  a_align: assert property (p_align)
    else $error("access not aligned to its width");
  a_code: assert property (p_code)
    else $error("illegal access width code");
  a_err_stop: assert property (p_err_stop)
    else $error("bus request kept after a bus error");
  a_wr_step: assert property (p_wr_step)
    else $error("split write not at next address");
  a_rd_step: assert property (p_rd_step)
    else $error("split read not at next address");
endmodule // dadc_engine_monitor

bind dadc_engine dadc_engine_monitor #(.NCH(NCH), .AW(AW)) dadc_engine_monitor_i (
  .mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sys_req(sys_req), .sys_we(sys_we), .sys_addr(sys_addr),
  .sys_size(sys_size), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
  .sys_err(sys_err));

// ---- dadc_params.svh ----
// constants for the dual-address dma channel engine
// assumes a single 125 MHz mclk domain and a plain register port
`ifndef DADC_PARAMS_SVH
`define DADC_PARAMS_SVH

// register port decode: byte address = {channel, register, 2'b00}
`define DADC_CH_LSB 5
`define DADC_REG_LSB 2
`define DADC_REG_SRC 3'h0
`define DADC_REG_DST 3'h1
`define DADC_REG_CNT 3'h2
`define DADC_REG_CTL 3'h3
`define DADC_REG_STATE 3'h4

// channel_control fields
`define DADC_CTL_W 20
`define DADC_CTL_START 0
`define DADC_CTL_UNIT 2
`define DADC_CTL_PORT 4
`define DADC_CTL_SIO 6
`define DADC_CTL_DIO 7
`define DADC_CTL_EXR 8
`define DADC_CTL_NIE 9
`define DADC_CTL_ABIE 10
`define DADC_CTL_LEV 12
`define DADC_CTL_POS 13
`define DADC_CTL_SMEM 16
`define DADC_CTL_DMEM 18
`define DADC_CTL_RST 20'h00000

// channel_state fields
`define DADC_ST_W 6
`define DADC_ST_ACT 0
`define DADC_ST_NC 1
`define DADC_ST_ABC 2
`define DADC_ST_CONF 3
`define DADC_ST_BES 4
`define DADC_ST_BED 5
`define DADC_ST_RST 6'h00

// width codes shared by unit, port and memory bus
`define DADC_SZ_32 2'h0
`define DADC_SZ_16 2'h2
`define DADC_SZ_8 2'h3

`endif

// ---- dadc_pkg.sv ----
// types shared by the dma engine and its request conditioner
// assumes dadc_params.svh is on the include path
package dadc_pkg;
  typedef enum logic [1:0] {DADC_IDLE, DADC_READ, DADC_WRITE} dadc_state_e;
  typedef logic [1:0] dadc_size_t;
endpackage

// ---- dadc_req_cond.sv ----
// external pin request conditioner, one lane per channel
// assumes pins are asynchronous to mclk; take comes from mclk logic
`timescale 1ns/1ps
`include "dadc_params.svh"

module dadc_req_cond #(
  parameter int N = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // raw pins and per-channel mode
  input wire logic [N-1:0] pin_n,
  input wire logic [N-1:0] level_sel,
  input wire logic [N-1:0] polarity_sel,
  // engine side
  input wire logic [N-1:0] take,
  output logic [N-1:0] pin_req
);
  import dadc_pkg::*;

  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prev;
    logic [N-1:0] pend;
  } dadc_cond_s;

  dadc_cond_s cond_r;
  dadc_cond_s cond_nxt;
  logic [N-1:0] act;

  ////////////////////////////////////////////////////////////////////////
  // active level after polarity; low-active when polarity bit is 0
  assign act = cond_r.s2 ^ ~polarity_sel;

  // s1 feeds only s2; edges are taken from s2 against its history
  always_comb
  begin
    cond_nxt = cond_r;
    cond_nxt.s1 = pin_n;
    cond_nxt.s2 = cond_r.s1;
    cond_nxt.prev = act;
    // set beats take so an edge during a grant is not lost
    cond_nxt.pend = (cond_r.pend & ~take) | (act & ~cond_r.prev);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      // sync stages and history start at the idle high pin level, so the
      // release of reset never looks like a falling request edge
      cond_r <= '{s1: '1, s2: '1, prev: '1, pend: '0};
    else
      cond_r <= cond_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // level mode passes the sampled level; nothing is kept for it
  assign pin_req = (level_sel & act) | (~level_sel & cond_r.pend);

endmodule // dadc_req_cond

// ---- dual_address_dma_channels_tb_top.sv ----
// self-checking bench for the dual-address dma engine
// assumes the bus model answers every access; one pin edge is driven
`timescale 1ns/1ps
module dual_address_dma_channels_tb_top;
  import dadc_pkg::*;
  localparam logic [31:0] SA = 32'h100;
  localparam logic [31:0] DA = 32'h200;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, sys_addr, sys_wdata, sys_rdata, v;
  logic sys_req, sys_we, sys_ack, sys_err, irq;
  logic slow = 1'b0;
  logic err_en = 1'b0;
  logic [31:0] err_addr = 32'h0;
  logic [7:0] intc_n = 8'hff;
  logic [7:0] pin_n = 8'hff;
  dadc_size_t sys_size;
  logic [31:0] la[$];
  logic [31:0] ld[$];
  logic lw[$];
  dadc_size_t ls[$];
  int bad_count = 0;
  int checked = 0;
  always #4 mclk = ~mclk;
  dadc_engine dadc_engine_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_req(sys_req), .sys_we(sys_we),
    .sys_addr(sys_addr), .sys_size(sys_size), .sys_wdata(sys_wdata),
    .sys_ack(sys_ack), .sys_err(sys_err), .sys_rdata(sys_rdata),
    .intc_transfer_req_n(intc_n), .pin_transfer_req_n(pin_n),
    .transfer_done_irq(irq));
  dadc_bus_model dadc_bus_model_i (.mclk(mclk), .rst_n(rst_n), .slow(slow),
    .err_en(err_en), .err_addr(err_addr), .sys_req(sys_req),
    .sys_addr(sys_addr), .sys_ack(sys_ack), .sys_err(sys_err),
    .sys_rdata(sys_rdata));
  ////////////////////////////////////////////////////////////////////////////
  // log every acked access (err answers are not logged); reads keep read data, writes write data
  always @(posedge mclk)
  begin
    if (sys_req === 1'b1 && sys_ack === 1'b1)
    begin
      la.push_back(sys_addr);
      ld.push_back(sys_we ? sys_wdata : sys_rdata);
      lw.push_back(sys_we);
      ls.push_back(sys_size);
    end
  end
  function automatic logic [31:0] eb(input logic [31:0] a);
    return {a[7:0] + 8'h3, a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]} ^ 32'h5a5a5a5a;
  endfunction
  function automatic logic [31:0] msk(input dadc_size_t s);
    return (s == 2'h3) ? 32'hff : (s == 2'h2) ? 32'hffff : 32'hffffffff;
  endfunction
  function automatic logic [7:0] ra(input int ch, input int idx);
    return 8'(ch * 32 + idx * 4);
  endfunction
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // register port master: one-cycle strobes launched after an edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // polls the active bit; a channel that never stops ends the run
  task automatic wait_done(input int ch);
    int i;
    for (i = 0; i < 100; i++)
    begin
      rd(ra(ch, 4), v);
      if (v[0] === 1'b0)
        break;
    end
    if (i == 100)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic setup(input int ch, input logic [31:0] s, d, n);
    wr(ra(ch, 4), 32'h3e);
    wr(ra(ch, 0), s);
    wr(ra(ch, 1), d);
    wr(ra(ch, 2), n);
    la.delete();
    ld.delete();
    lw.delete();
    ls.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // good transfer on channel 0, internal request, completion irq enabled
  task automatic xfer(input logic [31:0] ctl, n, input int nacc);
    setup(0, SA, DA, n);
    wr(ra(0, 3), ctl | 32'h1);
    wait_done(0);
    rd(ra(0, 3), v);
    chk("control", ctl, v);
    rd(ra(0, 4), v);
    chk("state", 32'h2, v);
    chk("irq", 32'h1, irq);
    rd(ra(0, 0), v);
    chk("source", SA + n, v);
    rd(ra(0, 2), v);
    chk("count", 32'h0, v);
    chk("accesses", nacc, la.size());
    chk("first read", SA, la[0]);
    foreach (la[k])
      if (lw[k])
        chk("wdata", eb(SA + la[k] - DA) & msk(ls[k]),
          ld[k] & msk(ls[k]));
  endtask
  // refused start: abnormal irq enabled, nothing may move
  task automatic cfgerr(input logic [31:0] ctl, s, n);
    setup(0, s, DA, n);
    wr(ra(0, 3), ctl | 32'h401);
    wait_done(0);
    rd(ra(0, 4), v);
    chk("conf state", 32'hc, v);
    chk("abnormal irq", 32'h1, irq);
    rd(ra(0, 0), v);
    chk("source kept", s, v);
    rd(ra(0, 2), v);
    chk("count kept", n, v);
    chk("no traffic", 32'h0, la.size());
  endtask
  task automatic berr(input logic [31:0] a, st);
    setup(0, SA, DA, 8);
    err_addr <= a;
    err_en <= 1'b1;
    wr(ra(0, 3), 32'h401);
    wait_done(0);
    err_en <= 1'b0;
    rd(ra(0, 4), v);
    chk("bus error state", st, v);
    chk("abnormal irq", 32'h1, irq);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd(ra(0, 4), v);
    chk("state reset", 32'h0, v);
    rd(8'h18, v);
    chk("unmapped", 32'h0, v);
    xfer(32'h20200, 32'h8, 6);
    slow <= 1'b1;
    xfer(32'h278, 32'h4, 6);
    slow <= 1'b0;
    xfer(32'h2bc, 32'h2, 4);
    xfer(32'h2a0, 32'h4, 3);
    wr(ra(0, 2), 32'h8);
    wr(ra(0, 3), 32'h401);
    rd(ra(0, 4), v);
    chk("start when done", 32'he, v);
    cfgerr(32'hc0, SA, 32'h8);
    cfgerr(32'h48, SA, 32'h8);
    cfgerr(32'h0, SA, 32'h6);
    cfgerr(32'h0, SA + 32'h2, 32'h8);
    cfgerr(32'h0, SA, 32'h0);
    berr(SA, 32'h14);
    berr(DA, 32'h24);
    setup(1, 32'h180, 32'h280, 32'h4);
    setup(0, SA, DA, 32'h4);
    wr(ra(1, 3), 32'h101);
    wr(ra(0, 3), 32'h101);
    repeat (8) @(posedge mclk);
    chk("standby quiet", 32'h0, la.size());
    intc_n <= 8'hfc;
    wait_done(1);
    intc_n <= 8'hff;
    chk("ch0 first", SA, la[0]);
    chk("ch1 after unit", 32'h180, la[2]);
    // pin edge request on channel 2, low active, edge mode
    setup(2, 32'h1c0, 32'h2c0, 32'h4);
    wr(ra(2, 3), 32'h101);
    repeat (8) @(posedge mclk);
    chk("pin quiet", 32'h0, la.size());
    pin_n <= 8'hfb;
    wait_done(2);
    pin_n <= 8'hff;
    chk("pin unit", 32'h1c0, la[0]);
    print_verdict();
  end
endmodule // dual_address_dma_channels_tb_top
